// File: common/bgn_pkg.sv
// Shared constants, register layouts and lookup tables for the brown-out and idle gate bank.
package bgn_pkg;

  // Bus and register geometry.
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] ALIGN_OK = 2'h0;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_BO_CTRL = 10'h01F;
  localparam logic [IDX_W-1:0] IDX_BO_TIMING = 10'h020;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h030;
  localparam logic [IDX_W-1:0] IDX_LSD = 10'h034;
  localparam logic [IDX_W-1:0] IDX_GATE = 10'h035;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h03B;

  // Field layouts of the stored registers and the live status view.
  typedef struct packed {
    logic [2:0] trim;
    logic shutdown_en;
    logic inf_hold;
    logic mute;
    logic hold_release;
    logic enable;
  } bgn_bo_ctrl_t;

  typedef struct packed {
    logic [2:0] rate;
    logic [1:0] step;
    logic [2:0] hold;
  } bgn_bo_timing_t;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic [1:0] level;
    logic rsvd_lo;
  } bgn_lsd_t;

  typedef struct packed {
    logic [2:0] delay;
    logic [1:0] level;
    logic enable;
    logic [1:0] rsvd;
  } bgn_gate_t;

  typedef struct packed {
    logic rsvd_hi;
    logic hold_mask;
    logic [5:0] rsvd_lo;
  } bgn_irq_mask_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic low_signal;
    logic gate_active;
    logic shutdown;
    logic mute;
    logic hold_active;
    logic hold_irq;
  } bgn_status_t;

  // Reset values.
  localparam bgn_bo_ctrl_t BO_CTRL_RST = 8'h01;
  localparam bgn_bo_timing_t BO_TIMING_RST = 8'h2E;
  localparam bgn_lsd_t LSD_RST = 8'h06;
  localparam bgn_gate_t GATE_RST = 8'hBD;
  localparam bgn_irq_mask_t IRQ_MASK_RST = 8'h40;
  localparam logic [1:0] GATE_RSVD_VAL = 2'h1;

  // Time base: one tick every 100 us of the 20 MHz clock.
  localparam int CLK_FREQ_MHZ = 20;
  localparam int TICK_TIME_US = 100;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam int TICK_CNT_W = 11;
  localparam int TMR_W = 14;

  // Hold times 0..1000 ms, in ticks.
  localparam logic [TMR_W-1:0] HOLD_TICKS [0:7] = '{
    14'h0000, 14'h0064, 14'h00FA, 14'h01F4, 14'h03E8, 14'h09C4, 14'h1388, 14'h2710};
  // Gate entry delays 400 us .. 1 s, in ticks.
  localparam logic [TMR_W-1:0] GATE_TICKS [0:7] = '{
    14'h0004, 14'h0006, 14'h0008, 14'h0014, 14'h0064, 14'h01F4, 14'h03E8, 14'h2710};

  // Levels as attenuation below full scale in 0.5 dB units.
  localparam logic [7:0] GATE_LVL_ATT [0:3] = '{8'hB4, 8'hC8, 8'hDC, 8'hF0};
  localparam logic [7:0] LSD_LVL_ATT [0:3] = '{8'hF3, 8'hCB, 8'hA3, 8'h8F};
  localparam logic [1:0] SW_MODE_LOW = 2'h3;

  // Over-current trim offsets in percent of nominal.
  localparam logic signed [7:0] TRIM_PCT [0:7] = '{
    8'sh00, 8'sh0A, 8'sh14, 8'sh1E, 8'shD8, 8'shE2, 8'shEC, 8'shF6};

  // Brown-out attack engine.
  localparam int ATK_CNT_W = 7;
  localparam int GAIN_W = 8;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hFF;

  typedef enum logic [2:0] {
    BO_IDLE = 3'b000,
    BO_ATTACK = 3'b001,
    BO_HOLD = 3'b010,
    BO_MUTE = 3'b011,
    BO_OFF = 3'b100
  } bgn_bo_state_t;

endpackage

// File: design/bgn_cfg_top.sv
// APB register bank with brown-out guard engine, low-signal detector and idle gate.
//
// Functional notes
// - Trim code selects percent offset of threshold.
// - Shutdown-on-brown-out enable bit, reset disabled.
// - Release bit clears infinite hold, reads zero.
// - Infinite hold waits release, else hold timer.
// - Mute selected means mute then shut down.
// - Attack applies one step every 2^N samples.
// - Attack step is 0.5 to 2 dB.
// - Hold time code selects 0 to 1000 ms.
// - Mode 3 low-signal detect uses selectable level.
// - Gate enters after programmed below-threshold delay.
// - Gate level code selects -90 to -120 dBFS.
// - Gate enable bit, reset enabled.
// - Maskable infinite hold interrupt, masked at reset.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module bgn_cfg_top
  import bgn_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sample_tick_in,
  input wire logic brownout_event_in,
  input wire logic [7:0] signal_att_in,
  input wire logic [1:0] supply_switch_mode_in,
  output logic [GAIN_W-1:0] brownout_gain_reduction_out,
  output logic brownout_mute_out,
  output logic brownout_shutdown_out,
  output logic brownout_hold_active_out,
  output logic brownout_hold_irq_out,
  output logic [2:0] high_side_current_limit_trim_out,
  output logic signed [7:0] high_side_current_limit_pct_out,
  output logic low_signal_detect_out,
  output logic idle_gate_active_out
);

  bgn_bo_ctrl_t bo_ctrl_q;
  bgn_bo_timing_t bo_timing_q;
  bgn_lsd_t lsd_q;
  bgn_gate_t gate_q;
  bgn_irq_mask_t irq_mask_q;
  bgn_status_t status_rd;
  bgn_lsd_t wr_lsd;
  bgn_gate_t wr_gate;
  bgn_irq_mask_t wr_mask;
  bgn_bo_ctrl_t wr_ctrl;
  bgn_status_t wr_status;
  logic hold_active_q;
  bgn_bo_state_t state_q;
  bgn_bo_state_t state_d;
  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic [REG_W-1:0] rd_byte;
  logic rd_hit;
  logic [IDX_W-1:0] idx;
  logic bus_done;
  logic wr_en;
  logic release_pulse_q;
  logic hold_irq_q;
  logic irq_q;
  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [ATK_CNT_W-1:0] atk_cnt_q;
  logic [ATK_CNT_W-1:0] atk_mask;
  logic [GAIN_W-1:0] gain_q;
  logic [GAIN_W:0] gain_sum;
  logic mute_q;
  logic shutdown_q;
  logic hold_done;
  logic gate_run;
  logic gate_done;
  logic low_sig_q;
  logic signed [7:0] pct_q;

  // Bus decode and write-data views.
  assign idx = paddr_in[ADDR_W-1:IDX_LSB];
  assign bus_done = psel_in && penable_in && pready_q;
  assign wr_en = bus_done && pwrite_in && rd_hit;
  assign wr_lsd = bgn_lsd_t'(pwdata_in[REG_W-1:0]);
  assign wr_gate = bgn_gate_t'(pwdata_in[REG_W-1:0]);
  assign wr_mask = bgn_irq_mask_t'(pwdata_in[REG_W-1:0]);
  assign wr_ctrl = bgn_bo_ctrl_t'(pwdata_in[REG_W-1:0]);
  assign wr_status = bgn_status_t'(pwdata_in[REG_W-1:0]);

  // Live status view.
  always_comb begin
    status_rd = '0;
    status_rd.hold_irq = hold_irq_q;
    status_rd.hold_active = (state_q == BO_HOLD);
    status_rd.mute = mute_q;
    status_rd.shutdown = shutdown_q;
    status_rd.gate_active = gate_done;
    status_rd.low_signal = low_sig_q;
  end

  // Read multiplexer; reserved bits read as zero except the gate's fixed pair.
  always_comb begin
    rd_byte = '0;
    rd_hit = (paddr_in[IDX_LSB-1:0] == ALIGN_OK);
    unique case (idx)
      IDX_BO_CTRL: begin
        rd_byte = bo_ctrl_q;
      end
      IDX_BO_TIMING: begin
        rd_byte = bo_timing_q;
      end
      IDX_STATUS: begin
        rd_byte = status_rd;
      end
      IDX_LSD: begin
        rd_byte = lsd_q;
      end
      IDX_GATE: begin
        rd_byte = gate_q;
      end
      IDX_IRQ_MASK: begin
        rd_byte = irq_mask_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait state: ready rises in the second access cycle with data and error.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (psel_in && penable_in && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !rd_hit;
      prdata_q <= (pwrite_in || !rd_hit) ? '0 : {{(DATA_W-REG_W){1'b0}}, rd_byte};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
  end

  // Brown-out control register; the release bit is never stored.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      bo_ctrl_q <= BO_CTRL_RST;
      release_pulse_q <= 1'b0;
    end else begin
      release_pulse_q <= 1'b0;
      if (wr_en && idx == IDX_BO_CTRL) begin
        bo_ctrl_q <= wr_ctrl;
        bo_ctrl_q.hold_release <= 1'b0;
        release_pulse_q <= wr_ctrl.hold_release;
      end
    end
  end

  // Timing, detector, gate and mask registers.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      bo_timing_q <= BO_TIMING_RST;
      lsd_q <= LSD_RST;
      gate_q <= GATE_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_en) begin
      if (idx == IDX_BO_TIMING) begin
        bo_timing_q <= bgn_bo_timing_t'(pwdata_in[REG_W-1:0]);
      end
      if (idx == IDX_LSD) begin
        lsd_q.level <= wr_lsd.level;
      end
      if (idx == IDX_GATE) begin
        gate_q <= wr_gate;
        gate_q.rsvd <= GATE_RSVD_VAL;
      end
      if (idx == IDX_IRQ_MASK) begin
        irq_mask_q.hold_mask <= wr_mask.hold_mask;
      end
    end
  end

  // 100 us tick for hold and gate timers.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Brown-out sequencer next state.
  always_comb begin
    state_d = state_q;
    if (!bo_ctrl_q.enable) begin
      state_d = BO_IDLE;
    end else begin
      unique case (state_q)
        BO_IDLE: begin
          if (brownout_event_in) begin
            state_d = bo_ctrl_q.mute ? BO_MUTE : (bo_ctrl_q.shutdown_en ? BO_OFF : BO_ATTACK);
          end
        end
        BO_ATTACK: begin
          if (brownout_event_in && bo_ctrl_q.shutdown_en) begin
            state_d = BO_OFF;
          end else if (!brownout_event_in) begin
            state_d = BO_HOLD;
          end
        end
        BO_HOLD: begin
          if (brownout_event_in) begin
            state_d = bo_ctrl_q.shutdown_en ? BO_OFF : BO_ATTACK;
          end else if (bo_ctrl_q.inf_hold) begin
            if (release_pulse_q) begin
              state_d = BO_IDLE;
            end
          end else if (hold_done) begin
            state_d = BO_IDLE;
          end
        end
        BO_MUTE: begin
          if (sample_tick_in) begin
            state_d = BO_OFF;
          end
        end
        BO_OFF: begin
          state_d = BO_OFF;
        end
        default: begin
          state_d = BO_IDLE;
        end
      endcase
    end
  end

  // Sequencer state and its mute and shutdown outputs.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= BO_IDLE;
      mute_q <= 1'b0;
      shutdown_q <= 1'b0;
      hold_active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_active_q <= (state_d == BO_HOLD);
      mute_q <= (state_d == BO_MUTE) || (state_d == BO_OFF && mute_q);
      shutdown_q <= (state_d == BO_OFF);
    end
  end

  bgn_delay_timer u_hold_timer (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .tick_in(tick_q),
    .run_in(state_q == BO_HOLD && !bo_ctrl_q.inf_hold),
    .load_in(HOLD_TICKS[bo_timing_q.hold]),
    .done_out(hold_done)
  );

  assign atk_mask = ATK_CNT_W'((8'h01 << bo_timing_q.rate) - 8'h01);
  assign gain_sum = {1'b0, gain_q} + {{(GAIN_W-2){1'b0}}, bo_timing_q.step} + 1'b1;

  // Attack counter and gain reduction in 0.5 dB units.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      atk_cnt_q <= '0;
      gain_q <= '0;
    end else if (state_q == BO_ATTACK && state_d == BO_ATTACK) begin
      if (sample_tick_in) begin
        atk_cnt_q <= atk_cnt_q + 1'b1;
        if ((atk_cnt_q & atk_mask) == atk_mask) begin
          gain_q <= gain_sum[GAIN_W] ? GAIN_MAX : gain_sum[GAIN_W-1:0];
        end
      end
    end else if (state_d == BO_ATTACK || state_d == BO_HOLD) begin
      atk_cnt_q <= '0;
    end else begin
      atk_cnt_q <= '0;
      gain_q <= '0;
    end
  end

  // Sticky infinite hold event and masked interrupt; a new event beats the clear.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      hold_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (state_q != BO_HOLD && state_d == BO_HOLD && bo_ctrl_q.inf_hold) begin
        hold_irq_q <= 1'b1;
      end else if (wr_en && idx == IDX_STATUS && wr_status.hold_irq) begin
        hold_irq_q <= 1'b0;
      end
      irq_q <= hold_irq_q && !irq_mask_q.hold_mask;
    end
  end

  assign gate_run = gate_q.enable && (signal_att_in > GATE_LVL_ATT[gate_q.level]);

  bgn_delay_timer u_gate_timer (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .tick_in(tick_q),
    .run_in(gate_run),
    .load_in(GATE_TICKS[gate_q.delay]),
    .done_out(gate_done)
  );

  // Low-signal detector and trim percentage outputs.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      low_sig_q <= 1'b0;
      pct_q <= TRIM_PCT[BO_CTRL_RST.trim];
    end else begin
      low_sig_q <= (supply_switch_mode_in == SW_MODE_LOW) &&
                   (signal_att_in > LSD_LVL_ATT[lsd_q.level]);
      pct_q <= TRIM_PCT[bo_ctrl_q.trim];
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign brownout_gain_reduction_out = gain_q;
  assign brownout_mute_out = mute_q;
  assign brownout_shutdown_out = shutdown_q;
  assign brownout_hold_active_out = hold_active_q;
  assign brownout_hold_irq_out = irq_q;
  assign high_side_current_limit_trim_out = bo_ctrl_q.trim;
  assign high_side_current_limit_pct_out = pct_q;
  assign low_signal_detect_out = low_sig_q;
  assign idle_gate_active_out = gate_done;

endmodule

// File: design/bgn_delay_timer.sv
// Tick-based countdown that reports completion while its run input stays high.
`timescale 1ns/1ps
module bgn_delay_timer
  import bgn_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic [TMR_W-1:0] load_in,
  output logic done_out
);

  logic [TMR_W-1:0] cnt_q;
  logic done_q;

  // Reloads while idle, then counts ticks down and latches done at zero.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !run_in) begin
      cnt_q <= load_in;
      done_q <= 1'b0;
    end else if (tick_in && !done_q) begin
      if (cnt_q == '0) begin
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign done_out = done_q;

endmodule

// File: dv/bgn_cfg_sva.sv
// Port-level checker for the brown-out and idle gate register bank.
`timescale 1ns/1ps
module bgn_cfg_sva
  import bgn_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic sample_tick_in,
  input wire logic brownout_event_in,
  input wire logic [7:0] signal_att_in,
  input wire logic [1:0] supply_switch_mode_in,
  input wire logic [GAIN_W-1:0] brownout_gain_reduction_out,
  input wire logic brownout_mute_out,
  input wire logic brownout_shutdown_out,
  input wire logic brownout_hold_active_out,
  input wire logic brownout_hold_irq_out,
  input wire logic [2:0] high_side_current_limit_trim_out,
  input wire logic signed [7:0] high_side_current_limit_pct_out,
  input wire logic low_signal_detect_out,
  input wire logic idle_gate_active_out
);
  // All checks run on the one clock and pause while reset is high.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // Bus handshake: exactly one wait state, one-cycle answers.
  a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("bus answer missing after one wait state");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("bus answer held too long");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("bus answer without access phase");
  a_read_quiet: assert property (prdata_out[31:8] == 24'h0 && (pready_out || prdata_out == 32'h0))
    else $error("read data outside its cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without answer");
  a_trim_percent: assert property (1'b1 |=> high_side_current_limit_pct_out ==
    TRIM_PCT[$past(high_side_current_limit_trim_out)]) else $error("trim percent wrong");
  a_gain_step: assert property (brownout_gain_reduction_out > $past(brownout_gain_reduction_out)
    |-> brownout_gain_reduction_out - $past(brownout_gain_reduction_out) <= 8'h04)
    else $error("gain step too large");
  a_mute_then_off: assert property (brownout_mute_out && !brownout_shutdown_out &&
    sample_tick_in |-> ##[1:2] (brownout_shutdown_out || !brownout_mute_out))
    else $error("mute not followed by shutdown");
  a_shut_cause: assert property ($rose(brownout_shutdown_out) |-> brownout_mute_out ||
    $past(brownout_event_in) || $past(brownout_event_in, 2)) else $error("stray shutdown");
  a_irq_cause: assert property ($rose(brownout_hold_irq_out) |-> $past(brownout_hold_active_out)
    || $past(pready_out) || $past(pready_out, 2)) else $error("stray hold interrupt");
  a_low_mode: assert property (low_signal_detect_out |->
    $past(supply_switch_mode_in) == SW_MODE_LOW && $past(signal_att_in) > 8'h8F)
    else $error("low-signal flag wrong");
  a_gate_drop: assert property (idle_gate_active_out && signal_att_in <= 8'hB4
    |=> !idle_gate_active_out) else $error("gate held on loud signal");
  a_gate_rise: assert property ($rose(idle_gate_active_out) |-> $past(signal_att_in) > 8'hB4)
    else $error("gate entered on loud signal");

  // Main scenarios reached.
  c_hold_irq: cover property (brownout_hold_active_out && brownout_hold_irq_out);
  c_mute_off: cover property (brownout_mute_out && brownout_shutdown_out);
  c_gate: cover property ($rose(idle_gate_active_out));
endmodule

bind bgn_cfg_top bgn_cfg_sva u_sva (.ref_clk_in, .srst_in, .psel_in, .penable_in, .prdata_out,
  .pready_out, .pslverr_out, .sample_tick_in, .brownout_event_in, .signal_att_in,
  .supply_switch_mode_in, .brownout_gain_reduction_out, .brownout_mute_out,
  .brownout_shutdown_out, .brownout_hold_active_out, .brownout_hold_irq_out,
  .high_side_current_limit_trim_out, .high_side_current_limit_pct_out,
  .low_signal_detect_out, .idle_gate_active_out);

// File: dv/tb_brownout_guard_noise_gate_cfg.sv
// Self-checking bench for the brown-out and idle gate register bank.
`timescale 1ns/1ps
module tb_brownout_guard_noise_gate_cfg;
  import bgn_pkg::*;
  typedef struct packed {
    logic wr;
    logic [IDX_W-1:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
    logic err;
  } bgn_row_t;

  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [DATA_W-1:0] pwdata_in = '0;
  logic sample_tick_in = 1'b0;
  logic brownout_event_in = 1'b0;
  logic [7:0] signal_att_in = 8'h00;
  logic [1:0] supply_switch_mode_in = 2'h0;
  logic [DATA_W-1:0] prdata_out;
  logic pready_out, pslverr_out, brownout_mute_out, brownout_shutdown_out;
  logic brownout_hold_active_out, brownout_hold_irq_out, low_signal_detect_out;
  logic idle_gate_active_out;
  logic [GAIN_W-1:0] brownout_gain_reduction_out;
  logic [2:0] high_side_current_limit_trim_out;
  logic signed [7:0] high_side_current_limit_pct_out;
  int bad_count = 0;
  int n_compared = 0;
  int i;
  logic [31:0] rd;
  logic er;
  logic [7:0] pct [0:7] = '{8'h00, 8'h0A, 8'h14, 8'h1E, 8'hD8, 8'hE2, 8'hEC, 8'hF6};
  // Reset values, access kinds and one unmapped place.
  bgn_row_t rows [0:10] = '{
    '{1'b0, IDX_BO_CTRL, 8'h00, 8'h01, 1'b0}, '{1'b0, IDX_BO_TIMING, 8'h00, 8'h2E, 1'b0},
    '{1'b0, IDX_LSD, 8'h00, 8'h06, 1'b0}, '{1'b0, IDX_GATE, 8'h00, 8'hBD, 1'b0},
    '{1'b0, IDX_IRQ_MASK, 8'h00, 8'h40, 1'b0}, '{1'b1, IDX_BO_CTRL, 8'hFF, 8'hFD, 1'b0},
    '{1'b1, IDX_BO_TIMING, 8'hFF, 8'hFF, 1'b0}, '{1'b1, IDX_LSD, 8'hFF, 8'h06, 1'b0},
    '{1'b1, IDX_GATE, 8'h00, 8'h01, 1'b0}, '{1'b1, IDX_IRQ_MASK, 8'hFF, 8'h40, 1'b0},
    '{1'b1, 10'h010, 8'hFF, 8'h00, 1'b1}};

  bgn_cfg_top DUT (.ref_clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sample_tick_in, .brownout_event_in,
    .signal_att_in, .supply_switch_mode_in, .brownout_gain_reduction_out, .brownout_mute_out,
    .brownout_shutdown_out, .brownout_hold_active_out, .brownout_hold_irq_out,
    .high_side_current_limit_trim_out, .high_side_current_limit_pct_out,
    .low_signal_detect_out, .idle_gate_active_out);

  // Clock of 50 ns period.
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic give_up(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // One bus transfer: setup, then access held until the answer.
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= {idx, ALIGN_OK};
    pwdata_in <= {24'h0, d};
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk_in);
      if (pready_out === 1'b1) break;
    end
    give_up(pready_out);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      sample_tick_in <= 1'b1;
      @(posedge ref_clk_in);
      sample_tick_in <= 1'b0;
      cyc(2);
    end
  endtask

  // A hang anywhere ends the run as a failure.
  initial begin
    cyc(90000);
    give_up(1'b0);
  end

  initial begin
    cyc(5);
    srst_in <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].wr) begin
        apb(1'b1, rows[k].idx, rows[k].wd);
      end
      apb(1'b0, rows[k].idx, 8'h00);
      chk(rd, {24'h0, rows[k].exp}); // readback value
      chk({31'h0, er}, {31'h0, rows[k].err}); // error flag
    end
    for (i = 0; i < 8; i++) begin
      apb(1'b1, IDX_BO_CTRL, {i[2:0], 5'h00});
      cyc(2);
      chk({29'h0, high_side_current_limit_trim_out}, i);
      chk({24'h0, high_side_current_limit_pct_out}, {24'h0, pct[i]});
    end
    // infinite hold with a 2 dB step every 2 samples.
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
    apb(1'b1, IDX_BO_TIMING, 8'h38);
    apb(1'b1, IDX_BO_CTRL, 8'h09);
    brownout_event_in <= 1'b1;
    cyc(3);
    ticks(4);
    chk({24'h0, brownout_gain_reduction_out}, 32'h8);
    brownout_event_in <= 1'b0;
    cyc(4);
    ticks(2);
    chk({31'h0, brownout_hold_active_out}, 32'h1);
    chk({31'h0, brownout_hold_irq_out}, 32'h1);
    chk({24'h0, brownout_gain_reduction_out}, 32'h8);
    apb(1'b1, IDX_BO_CTRL, 8'h0B);
    cyc(3);
    chk({31'h0, brownout_hold_active_out}, 32'h0);
    chk({24'h0, brownout_gain_reduction_out}, 32'h0);
    apb(1'b0, IDX_BO_CTRL, 8'h00);
    chk(rd, 32'h09); // self-clear
    // mask, unmask and clear the sticky flag.
    apb(1'b1, IDX_IRQ_MASK, 8'h40);
    cyc(2);
    chk({31'h0, brownout_hold_irq_out}, 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
    cyc(2);
    chk({31'h0, brownout_hold_irq_out}, 32'h1);
    apb(1'b1, IDX_STATUS, 8'h01);
    cyc(2);
    chk({31'h0, brownout_hold_irq_out}, 32'h0);
    // mute, then shutdown on the next sample.
    apb(1'b1, IDX_BO_CTRL, 8'h05);
    brownout_event_in <= 1'b1;
    cyc(4);
    chk({30'h0, brownout_mute_out, brownout_shutdown_out}, 32'h2);
    ticks(1);
    chk({30'h0, brownout_mute_out, brownout_shutdown_out}, 32'h3);
    apb(1'b1, IDX_BO_CTRL, 8'h00);
    cyc(5);
    chk({22'h0, brownout_gain_reduction_out, brownout_mute_out, brownout_shutdown_out}, 0);
    apb(1'b1, IDX_BO_CTRL, 8'h11);
    cyc(4);
    chk({30'h0, brownout_mute_out, brownout_shutdown_out}, 32'h1);
    apb(1'b1, IDX_BO_CTRL, 8'h00);
    brownout_event_in <= 1'b0;
    // timed hold: code 0 ends at the next tick, code 1 still holds.
    apb(1'b1, IDX_BO_TIMING, 8'h00);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, IDX_BO_CTRL, 8'h01);
      brownout_event_in <= 1'b1;
      ticks(1);
      chk({24'h0, brownout_gain_reduction_out}, 32'h1);
      brownout_event_in <= 1'b0;
      cyc(4500);
      chk({31'h0, brownout_hold_active_out}, i);
      apb(1'b1, IDX_BO_TIMING, 8'h01);
    end
    apb(1'b1, IDX_BO_CTRL, 8'h00);
    // gate at -90 dBFS with the 400 us delay.
    apb(1'b1, IDX_GATE, 8'h04);
    signal_att_in <= 8'hB5;
    cyc(5500);
    chk({31'h0, idle_gate_active_out}, 32'h0); // too early
    for (i = 0; i < 7000 && idle_gate_active_out !== 1'b1; i++) @(posedge ref_clk_in);
    chk({31'h0, idle_gate_active_out}, 32'h1);
    give_up(idle_gate_active_out);
    signal_att_in <= 8'hB4;
    cyc(2);
    chk({31'h0, idle_gate_active_out}, 32'h0); // boundary
    // disabled gate stays open; then -120 dBFS level.
    apb(1'b1, IDX_GATE, 8'h00);
    signal_att_in <= 8'hF1;
    cyc(12000);
    chk({31'h0, idle_gate_active_out}, 32'h0);
    apb(1'b1, IDX_GATE, 8'h1C);
    for (i = 0; i < 12000 && idle_gate_active_out !== 1'b1; i++) @(posedge ref_clk_in);
    chk({31'h0, idle_gate_active_out}, 32'h1);
    give_up(idle_gate_active_out);
    // low-signal detect levels in mode 3 only.
    supply_switch_mode_in <= 2'h3;
    cyc(3);
    chk({31'h0, low_signal_detect_out}, 32'h1);
    supply_switch_mode_in <= 2'h0;
    cyc(3);
    chk({31'h0, low_signal_detect_out}, 32'h0);
    apb(1'b1, IDX_LSD, 8'h00);
    supply_switch_mode_in <= 2'h3;
    cyc(3);
    chk({31'h0, low_signal_detect_out}, 32'h0);
    signal_att_in <= 8'hF4;
    cyc(3);
    chk({31'h0, low_signal_detect_out}, 32'h1);
    srst_in <= 1'b1;
    cyc(2);
    srst_in <= 1'b0;
    apb(1'b0, IDX_BO_CTRL, 8'h00);
    chk(rd, 32'h01);
    apb(1'b0, IDX_GATE, 8'h00);
    chk(rd, 32'hBD);
    tally_and_finish();
  end
endmodule
